// *** hw/dcs_pkg.sv ***
// Package for the drive control source selector and input interpreter
package dcs_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CFG = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_REMOTE = 8'h0C;
  localparam logic [7:0] OFS_SPEED = 8'h10;

  // Source selector values
  localparam logic [2:0] SRC_TERMINAL = 3'h0;
  localparam logic [2:0] SRC_KEYPAD_A = 3'h1;
  localparam logic [2:0] SRC_KEYPAD_B = 3'h2;
  localparam logic [2:0] SRC_PI = 3'h3;
  localparam logic [2:0] SRC_FIELDBUS = 3'h4;
  localparam logic [2:0] SRC_SLAVE = 3'h5;
  localparam logic [2:0] SRC_BACNET = 3'h6;

  // Speed reference choices reported in status
  localparam logic [2:0] REF_AIN1 = 3'h0;
  localparam logic [2:0] REF_KEYPAD = 3'h1;
  localparam logic [2:0] REF_PI = 3'h2;
  localparam logic [2:0] REF_FIELDBUS = 3'h3;
  localparam logic [2:0] REF_MODBUS = 3'h4;
  localparam logic [2:0] REF_MASTER = 3'h5;
  localparam logic [2:0] REF_BACNET = 3'h6;

  // Terminal macro: how digital inputs 1..4 are read
  localparam logic [2:0] MAC_LATCH_RUN = 3'h0;
  localparam logic [2:0] MAC_LATCH_DIR = 3'h1;
  localparam logic [2:0] MAC_LATCH_FR = 3'h2;
  localparam logic [2:0] MAC_MOM_START = 3'h3;
  localparam logic [2:0] MAC_MOM_DIR = 3'h4;
  localparam logic [2:0] MAC_MOM_PAIR = 3'h5;

  // Reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  localparam logic [31:0] SPEED_RST = 32'h0000_0000;

  // Field positions in CTRL
  localparam int CTRL_SRC_LSB = 0;
  localparam int CTRL_MAC_LSB = 4;
  localparam int CTRL_AIN1_LSB = 8;
  localparam int CTRL_AIN2_LSB = 12;
  // Field positions in CFG
  localparam int CFG_AUTOSTART = 0;
  localparam int CFG_KP_ENABLE_STARTS = 1;
  localparam int CFG_KP_DI1_START = 2;
  localparam int CFG_FASTSTOP_LSB = 8;
  localparam int CFG_KP_FREQ_LSB = 16;
  // Field positions in REMOTE
  localparam int REM_FB_PRESENT = 0;
  localparam int REM_START = 1;
  localparam int REM_STOP = 2;
  localparam int REM_REV = 3;
  localparam int REM_KP_START = 4;
  localparam int REM_KP_STOP = 5;

  typedef enum logic [2:0] {
    RUN_IDLE = 3'b001,
    RUN_FWD = 3'b010,
    RUN_REV = 3'b100
  } dcs_run_e;

  typedef struct packed {
    logic run;
    logic reverse;
    logic fast_stop;
    logic [2:0] ref_sel;
    logic [15:0] freq;
  } dcs_cmd_s;

  typedef struct packed {
    logic start;
    logic stop;
    logic rev;
  } dcs_remote_s;
endpackage

// *** hw/dcs_top.sv ***
// Drive control source selector and terminal input interpreter
//
// Function
// [RL1] Source 0: terminals, analog input 1
// [RL2] Source 1/2: keypad start/stop, keypad reference
// [RL3] Option: digital input 1 starts keypad mode
// [RL4] Source 3: terminal enable, PI frequency
// [RL5] Source 4: fieldbus module else Modbus
// [RL6] Source 5: follow master start, stop, frequency
// [RL7] Source 6: BACnet run and reference
// [RL8] Sources 4-6 need digital input 1 closed
// [RL9] Latched stop opens: drive stops
// [RL10] Latched run: runs only while closed
// [RL11] Latched direction inputs pick rotation
// [RL12] Run forward/reverse inputs run while closed
// [RL13] Keypad enable starts or only permits
// [RL14] Remote start accepted only with enable
// [RL15] Momentary start rising edge, stop closed
// [RL16] Both start inputs together start drive
// [RL17] Momentary stop falling edge stops drive
// [RL18] Directional momentary starts on rising edge
// [RL19] Power-on autostart when enable present
// [RL20] Keypad start frequency and start-key need
// [RL21] Analog input format settings per input
// [RL22] Fast-stop pair together uses fast ramp
// [RL23] Inputs synchronised before edge detection
`timescale 1ns/1ps
module dcs_top
  import dcs_pkg::*;
(
  input wire logic REF_CLK_I,
  input wire logic RESETN_I,
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  input wire logic [3:0] DIG_IN_I,
  input wire logic [15:0] AIN1_REF_I,
  input wire logic [15:0] PI_REF_I,
  input wire logic [15:0] FB_REF_I,
  input wire logic [15:0] MODBUS_REF_I,
  input wire logic [15:0] BACNET_REF_I,
  input wire logic [2:0] BACNET_CMD_I,
  input wire logic MASTER_RUN_I,
  input wire logic MASTER_REV_I,
  input wire logic [15:0] MASTER_FREQ_I,
  output logic [31:0] HRDATA_O,
  output logic HREADYOUT_O,
  output logic HRESP_O,
  output logic RUN_O,
  output logic REVERSE_O,
  output logic FAST_STOP_O,
  output logic [2:0] REF_SEL_O,
  output logic [15:0] FREQ_REF_O,
  output logic [3:0] AIN1_FORMAT_O,
  output logic [3:0] AIN2_FORMAT_O,
  output logic [7:0] FAST_STOP_RAMP_O
);

  function automatic logic rise(input logic now, input logic prev);
    rise = now & ~prev;
  endfunction

  function automatic logic fall(input logic now, input logic prev);
    fall = ~now & prev;
  endfunction

  logic [31:0] ctrl_q;
  logic [31:0] cfg_q;
  logic [31:0] remote_q;
  logic [15:0] kp_speed_q;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic [3:0] prev_q;
  logic [2:0] rem_prev_q;
  logic kp_start_prev_q;
  logic kp_stop_prev_q;
  logic boot_q;
  dcs_run_e run_q;
  dcs_run_e run_d;
  dcs_cmd_s cmd_d;
  logic fast_stop_q;

  logic [2:0] src;
  logic [2:0] mac;
  logic keypad_mode;
  logic remote_mode;
  logic di1;
  logic di2;
  logic di3;
  logic di4;
  dcs_remote_s rem;
  logic kp_start_ev;
  logic kp_stop_ev;
  logic addr_ok;
  logic fast_stop_d;

  assign src = ctrl_q[CTRL_SRC_LSB +: 3];
  assign mac = ctrl_q[CTRL_MAC_LSB +: 3];
  assign keypad_mode = (src == SRC_KEYPAD_A) || (src == SRC_KEYPAD_B);
  assign remote_mode = (src == SRC_FIELDBUS) || (src == SRC_SLAVE) || (src == SRC_BACNET);
  assign di1 = sync2_q[0];
  assign di2 = sync2_q[1];
  assign di3 = sync2_q[2];
  assign di4 = sync2_q[3];
  assign kp_start_ev = rise(remote_q[REM_KP_START], kp_start_prev_q);
  assign kp_stop_ev = rise(remote_q[REM_KP_STOP], kp_stop_prev_q);

  // AHB-Lite slave: zero wait states, always OKAY
  assign addr_ok = HSEL_I && HREADY_I && HTRANS_I[1];

  always_ff @(posedge REF_CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end
    else if (HREADY_I)
    begin
      wr_pend_q <= addr_ok && HWRITE_I;
      wr_addr_q <= HADDR_I[7:0];
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      ctrl_q <= CTRL_RST;
      cfg_q <= CFG_RST;
      remote_q <= 32'h0000_0000;
      kp_speed_q <= SPEED_RST[15:0];
    end
    else if (wr_pend_q)
    begin
      if (wr_addr_q == OFS_CTRL)
      begin
        ctrl_q <= HWDATA_I & 32'h0000_FF77;
      end
      else if (wr_addr_q == OFS_CFG)
      begin
        cfg_q <= HWDATA_I & 32'hFFFF_FF07;
      end
      else if (wr_addr_q == OFS_REMOTE)
      begin
        remote_q <= HWDATA_I & 32'h0000_003F;
      end
      else if (wr_addr_q == OFS_SPEED)
      begin
        kp_speed_q <= HWDATA_I[15:0];
      end
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      HRDATA_O <= 32'h0000_0000;
    end
    else if (addr_ok && !HWRITE_I)
    begin
      if (HADDR_I[7:0] == OFS_CTRL)
      begin
        HRDATA_O <= ctrl_q;
      end
      else if (HADDR_I[7:0] == OFS_CFG)
      begin
        HRDATA_O <= cfg_q;
      end
      else if (HADDR_I[7:0] == OFS_STATUS)
      begin
        HRDATA_O <= {FREQ_REF_O, 4'h0, di4, di3, di2, di1, 1'b0, REF_SEL_O,
                     1'b0, FAST_STOP_O, REVERSE_O, RUN_O};
      end
      else if (HADDR_I[7:0] == OFS_REMOTE)
      begin
        HRDATA_O <= remote_q;
      end
      else if (HADDR_I[7:0] == OFS_SPEED)
      begin
        HRDATA_O <= {16'h0000, kp_speed_q};
      end
      else
      begin
        HRDATA_O <= 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      HREADYOUT_O <= 1'b0;
      HRESP_O <= 1'b0;
    end
    else
    begin
      HREADYOUT_O <= 1'b1;
      HRESP_O <= 1'b0;
    end
  end

  // [RL23] Two-stage input sync
  always_ff @(posedge REF_CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
      prev_q <= 4'h0;
    end
    else
    begin
      sync1_q <= DIG_IN_I;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      rem_prev_q <= 3'h0;
      kp_start_prev_q <= 1'b0;
      kp_stop_prev_q <= 1'b0;
    end
    else
    begin
      rem_prev_q <= {rem.rev, rem.stop, rem.start};
      kp_start_prev_q <= remote_q[REM_KP_START];
      kp_stop_prev_q <= remote_q[REM_KP_STOP];
    end
  end

  // Remote command source mux
  always_comb
  begin
    rem.start = 1'b0;
    rem.stop = 1'b0;
    rem.rev = 1'b0;
    if (src == SRC_FIELDBUS)
    begin
      rem.start = remote_q[REM_START];
      rem.stop = remote_q[REM_STOP];
      rem.rev = remote_q[REM_REV];
    end
    else if (src == SRC_SLAVE)
    begin
      rem.start = MASTER_RUN_I;
      rem.stop = ~MASTER_RUN_I;
      rem.rev = MASTER_REV_I;
    end
    else if (src == SRC_BACNET)
    begin
      rem.start = BACNET_CMD_I[0];
      rem.stop = BACNET_CMD_I[1];
      rem.rev = BACNET_CMD_I[2];
    end
  end

  // Power-on start armed until the first run or enable opening; config resets
  // to zero, so a one-cycle window could never see the option set
  always_ff @(posedge REF_CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      boot_q <= 1'b1;
    end
    else if ((run_q != RUN_IDLE) || fall(di1, prev_q[0]))
    begin
      boot_q <= 1'b0;
    end
  end

  always_comb
  begin
    run_d = run_q;
    fast_stop_d = 1'b0;
    if (keypad_mode)
    begin
      // [RL19] Power-on autostart
      if (boot_q && cfg_q[CFG_AUTOSTART] && di1)
      begin
        run_d = RUN_FWD;
      end
      // [RL13] [RL20] Enable starts or permits
      if (cfg_q[CFG_KP_ENABLE_STARTS] && rise(di1, prev_q[0]))
      begin
        run_d = RUN_FWD;
      end
      // [RL3] Start from digital input 1
      if (cfg_q[CFG_KP_DI1_START] && rise(di1, prev_q[0]))
      begin
        run_d = RUN_FWD;
      end
      // [RL2] Keypad buttons
      if (kp_start_ev && di1)
      begin
        run_d = RUN_FWD;
      end
      if (kp_stop_ev || !di1)
      begin
        run_d = RUN_IDLE;
      end
    end
    else if (remote_mode)
    begin
      // [RL14] Start only with enable
      if (di1 && rise(rem.start, rem_prev_q[0]))
      begin
        run_d = rem.rev ? RUN_REV : RUN_FWD;
      end
      if (run_q != RUN_IDLE)
      begin
        run_d = rem.rev ? RUN_REV : RUN_FWD;
      end
      if (rem.stop)
      begin
        run_d = RUN_IDLE;
      end
      // [RL8] Digital input 1 gates running
      if (!di1)
      begin
        run_d = RUN_IDLE;
      end
    end
    else
    begin
      case (mac)
        MAC_LATCH_RUN:
        begin
          // [RL10] [RL9] Run while closed
          run_d = di1 ? RUN_FWD : RUN_IDLE;
        end
        MAC_LATCH_DIR:
        begin
          // [RL11] Direction selects rotation
          run_d = !di1 ? RUN_IDLE : (di2 ? RUN_REV : RUN_FWD);
        end
        MAC_LATCH_FR:
        begin
          // [RL12] Forward wins if both closed
          run_d = di1 ? RUN_FWD : (di2 ? RUN_REV : RUN_IDLE);
        end
        MAC_MOM_START:
        begin
          // [RL15] Rising edge with stop closed
          if (rise(di1, prev_q[0]) && di2)
          begin
            run_d = RUN_FWD;
          end
          // [RL17] Stop on falling edge
          if (fall(di2, prev_q[1]))
          begin
            run_d = RUN_IDLE;
          end
        end
        MAC_MOM_DIR:
        begin
          // [RL18] Directional momentary start
          if (rise(di1, prev_q[0]) && di2)
          begin
            run_d = RUN_FWD;
          end
          else if (rise(di3, prev_q[2]) && di2)
          begin
            run_d = RUN_REV;
          end
          if (fall(di2, prev_q[1]))
          begin
            run_d = RUN_IDLE;
          end
        end
        MAC_MOM_PAIR:
        begin
          // [RL16] Both start inputs together
          if (di1 && di3 && !(prev_q[0] && prev_q[2]) && di2)
          begin
            run_d = RUN_FWD;
          end
          if (fall(di2, prev_q[1]))
          begin
            run_d = RUN_IDLE;
          end
          // [RL22] Fast-stop pair together
          if (di2 == 1'b0 && di4 == 1'b0 && (prev_q[1] || prev_q[3]))
          begin
            run_d = RUN_IDLE;
            fast_stop_d = 1'b1;
          end
        end
        default:
        begin
          run_d = RUN_IDLE;
        end
      endcase
    end
  end

  // Reference selection per source
  always_comb
  begin
    cmd_d.ref_sel = REF_AIN1;
    cmd_d.freq = AIN1_REF_I;
    // [RL1] Terminal source
    if (src == SRC_TERMINAL)
    begin
      cmd_d.ref_sel = REF_AIN1;
      cmd_d.freq = AIN1_REF_I;
    end
    // [RL2] [RL20] Keypad reference
    else if (keypad_mode)
    begin
      cmd_d.ref_sel = REF_KEYPAD;
      cmd_d.freq = (run_q == RUN_IDLE) ? cfg_q[CFG_KP_FREQ_LSB +: 16] : kp_speed_q;
    end
    // [RL4] PI output
    else if (src == SRC_PI)
    begin
      cmd_d.ref_sel = REF_PI;
      cmd_d.freq = PI_REF_I;
    end
    // [RL5] Module or Modbus
    else if (src == SRC_FIELDBUS)
    begin
      cmd_d.ref_sel = remote_q[REM_FB_PRESENT] ? REF_FIELDBUS : REF_MODBUS;
      cmd_d.freq = remote_q[REM_FB_PRESENT] ? FB_REF_I : MODBUS_REF_I;
    end
    // [RL6] Follow master
    else if (src == SRC_SLAVE)
    begin
      cmd_d.ref_sel = REF_MASTER;
      cmd_d.freq = MASTER_FREQ_I;
    end
    // [RL7] BACnet
    else if (src == SRC_BACNET)
    begin
      cmd_d.ref_sel = REF_BACNET;
      cmd_d.freq = BACNET_REF_I;
    end
    cmd_d.run = (run_d != RUN_IDLE);
    cmd_d.reverse = (run_d == RUN_REV);
    cmd_d.fast_stop = fast_stop_d;
  end

  always_ff @(posedge REF_CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      run_q <= RUN_IDLE;
      fast_stop_q <= 1'b0;
    end
    else
    begin
      run_q <= run_d;
      fast_stop_q <= cmd_d.fast_stop;
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      RUN_O <= 1'b0;
      REVERSE_O <= 1'b0;
      FAST_STOP_O <= 1'b0;
      REF_SEL_O <= REF_AIN1;
      FREQ_REF_O <= 16'h0000;
      AIN1_FORMAT_O <= 4'h0;
      AIN2_FORMAT_O <= 4'h0;
      FAST_STOP_RAMP_O <= 8'h00;
    end
    else
    begin
      RUN_O <= cmd_d.run;
      REVERSE_O <= cmd_d.reverse;
      FAST_STOP_O <= cmd_d.fast_stop | fast_stop_q;
      REF_SEL_O <= cmd_d.ref_sel;
      FREQ_REF_O <= cmd_d.freq;
      // [RL21] Analog format fields
      AIN1_FORMAT_O <= ctrl_q[CTRL_AIN1_LSB +: 4];
      AIN2_FORMAT_O <= ctrl_q[CTRL_AIN2_LSB +: 4];
      FAST_STOP_RAMP_O <= cfg_q[CFG_FASTSTOP_LSB +: 8];
    end
  end

endmodule

// *** verification/dcs_top_assertions.sv ***
// Port checker for the control source selector
`timescale 1ns/1ps
module dcs_top_chk
  import dcs_pkg::*;
(
  input wire logic REF_CLK_I,
  input wire logic RESETN_I,
  input wire logic HSEL_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic HREADY_I,
  input wire logic [3:0] DIG_IN_I,
  input wire logic [15:0] AIN1_REF_I,
  input wire logic [15:0] PI_REF_I,
  input wire logic [15:0] BACNET_REF_I,
  input wire logic MASTER_RUN_I,
  input wire logic [31:0] HRDATA_O,
  input wire logic HREADYOUT_O,
  input wire logic HRESP_O,
  input wire logic RUN_O,
  input wire logic FAST_STOP_O,
  input wire logic [2:0] REF_SEL_O,
  input wire logic [15:0] FREQ_REF_O
);
  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (!RESETN_I);

  a_resp_okay: assert property (HRESP_O == 1'h0)
    else $error("hresp not okay");
  a_ready_high: assert property ($past(RESETN_I) |-> HREADYOUT_O)
    else $error("wait state inserted");
  a_rdata_hold: assert property (!(HSEL_I && HREADY_I && HTRANS_I[1] && !HWRITE_I)
    |=> $stable(HRDATA_O))
    else $error("read data moved");
  a_fast_pulse: assert property ($rose(FAST_STOP_O) |=> FAST_STOP_O ##1 !FAST_STOP_O)
    else $error("fast stop pulse width");
  a_fast_halt: assert property ($rose(FAST_STOP_O) |-> ##[0:2] !RUN_O)
    else $error("fast stop left drive running");
  // Remote sources counted from the fieldbus code upwards
  a_enable_gate: assert property ((REF_SEL_O >= REF_FIELDBUS && !DIG_IN_I[0]) [*4]
    |-> !RUN_O)
    else $error("ran without input 1");
  a_ain1_ref: assert property ((REF_SEL_O == REF_AIN1 && $stable(AIN1_REF_I)) [*3]
    |-> FREQ_REF_O == AIN1_REF_I)
    else $error("analog reference not followed");
  a_pi_ref: assert property ((REF_SEL_O == REF_PI && $stable(PI_REF_I)) [*3]
    |-> FREQ_REF_O == PI_REF_I)
    else $error("pi reference not followed");
  a_bac_ref: assert property ((REF_SEL_O == REF_BACNET && $stable(BACNET_REF_I)) [*3]
    |-> FREQ_REF_O == BACNET_REF_I)
    else $error("bacnet reference not followed");
  a_slave_stop: assert property ((REF_SEL_O == REF_MASTER && !MASTER_RUN_I) [*4]
    |-> !RUN_O)
    else $error("slave ran with master stopped");
endmodule

bind dcs_top dcs_top_chk i_dcs_top_chk (.*);

// *** verification/dcs_far_model.sv ***
// Contacts, master drive and network references on the far side
`timescale 1ns/1ps
module dcs_far_model
(
  input wire logic clk_i,
  output logic [3:0] dig_in_o,
  output logic [15:0] ain1_o,
  output logic [15:0] pi_o,
  output logic [15:0] fb_o,
  output logic [15:0] mb_o,
  output logic [15:0] bac_o,
  output logic [15:0] mst_freq_o,
  output logic [2:0] bac_cmd_o,
  output logic mst_run_o,
  output logic mst_rev_o
);
  // Distinct values so a wrong selection shows
  initial ain1_o = 16'h1111;
  initial pi_o = 16'h2222;
  assign fb_o = 16'h3333;
  assign mb_o = 16'h4444;
  assign mst_freq_o = 16'h5555;
  assign bac_o = 16'h6666;
  initial dig_in_o = 4'h0;
  initial bac_cmd_o = 3'h0;
  initial mst_run_o = 1'h0;
  initial mst_rev_o = 1'h0;
  task set_di(input logic [3:0] v);
    @(posedge clk_i);
    dig_in_o <= v;
  endtask
  task set_ref(input logic [15:0] a, input logic [15:0] p);
    @(posedge clk_i);
    ain1_o <= a;
    pi_o <= p;
  endtask
  task set_bac(input logic [2:0] v);
    @(posedge clk_i);
    bac_cmd_o <= v;
  endtask
  task set_mst(input logic r, input logic d);
    @(posedge clk_i);
    mst_run_o <= r;
    mst_rev_o <= d;
  endtask
endmodule

// *** verification/tb_dcs_top.sv ***
// Self-checking bench for the control source selector
`timescale 1ns/1ps
module tb_dcs_top;
  import dcs_pkg::*;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic hsel = 1'h0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'h0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic hready, hresp, run, rev, fst, mrun, mrev;
  logic [2:0] rsel, bcmd;
  logic [15:0] fref, a1, pi, fb, mb, bac, mf;
  logic [3:0] di, f1, f2;
  logic [7:0] ramp;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cyc = 0;

  dcs_far_model i_dcs_far_model (.clk_i(clk), .dig_in_o(di), .ain1_o(a1), .pi_o(pi),
    .fb_o(fb), .mb_o(mb), .bac_o(bac), .mst_freq_o(mf), .bac_cmd_o(bcmd),
    .mst_run_o(mrun), .mst_rev_o(mrev));
  dcs_top i_dcs_top (.REF_CLK_I(clk), .RESETN_I(rst_n), .HSEL_I(hsel), .HADDR_I(haddr),
    .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata),
    .HREADY_I(hready), .DIG_IN_I(di), .AIN1_REF_I(a1), .PI_REF_I(pi), .FB_REF_I(fb),
    .MODBUS_REF_I(mb), .BACNET_REF_I(bac), .BACNET_CMD_I(bcmd), .MASTER_RUN_I(mrun),
    .MASTER_REV_I(mrev), .MASTER_FREQ_I(mf), .HRDATA_O(hrdata), .HREADYOUT_O(hready),
    .HRESP_O(hresp), .RUN_O(run), .REVERSE_O(rev), .FAST_STOP_O(fst), .REF_SEL_O(rsel),
    .FREQ_REF_O(fref), .AIN1_FORMAT_O(f1), .AIN2_FORMAT_O(f2), .FAST_STOP_RAMP_O(ramp));

  initial forever #2 clk = ~clk;

  task tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Whole run is well under this; a hung handshake ends here
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 8000)
    begin
      n_mismatch = n_mismatch + 1;
      tally_and_finish();
    end
  end

  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task w(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task ap(input logic [7:0] a, input logic wr_n);
    @(posedge clk);
    hsel <= 1'h1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= wr_n;
    do @(posedge clk); while (hready !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    ap(a, 1'h1);
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'h1);
  endtask
  task rd(input logic [7:0] a, output logic [31:0] q);
    ap(a, 1'h0);
    do @(posedge clk); while (hready !== 1'h1);
    q = hrdata;
  endtask
  task ctl(input logic [2:0] s, input logic [2:0] m);
    wr(OFS_CTRL, {25'h000_0000, m, 1'h0, s});
    w(3);
  endtask
  task rm(input logic [5:0] v);
    wr(OFS_REMOTE, {26'h000_0000, v});
  endtask
  // Direction left unchecked when given as unknown
  task ck(input logic r, input logic d);
    w(5);
    chk("run", run, r);
    if (d !== 1'hx)
      chk("reverse", rev, d);
  endtask
  task dc(input logic [3:0] v, input logic r, input logic d);
    i_dcs_far_model.set_di(v);
    ck(r, d);
  endtask

  task t_regs();
    logic [31:0] q;
    rd(OFS_CTRL, q);
    chk("ctrl", q, CTRL_RST);
    rd(OFS_CFG, q);
    chk("cfg", q, CFG_RST);
    wr(8'h40, 32'hFFFF_FFFF);
    rd(8'h40, q);
    chk("unmapped", q, 32'h0000_0000);
    wr(OFS_CTRL, 32'h0000_A500);
    wr(OFS_CFG, 32'h0000_3C00);
    w(3);
    chk("ain1_fmt", f1, 4'h5);
    chk("ain2_fmt", f2, 4'hA);
    chk("ramp", ramp, 8'h3C);
    rd(OFS_CTRL, q);
    chk("ctrl", q, 32'h0000_A500);
    chk("hresp", hresp, 1'h0);
    $display("test regs done");
  endtask

  task t_src();
    logic [2:0] er [7];
    logic [15:0] ef [7];
    er = '{REF_AIN1, REF_KEYPAD, REF_KEYPAD, REF_PI, REF_MODBUS, REF_MASTER, REF_BACNET};
    ef = '{16'h1111, 16'h0000, 16'h0000, 16'h2222, 16'h4444, 16'h5555, 16'h6666};
    for (int i = 0; i < 7; i++)
    begin
      ctl(i[2:0], MAC_LATCH_RUN);
      chk("ref_sel", rsel, er[i]);
      if (ef[i] !== 16'h0000)
        chk("freq", fref, ef[i]);
    end
    ctl(SRC_FIELDBUS, MAC_LATCH_RUN);
    rm(6'h01);
    w(3);
    chk("ref_sel", rsel, REF_FIELDBUS);
    chk("freq", fref, 16'h3333);
    rm(6'h00);
    ctl(SRC_PI, MAC_LATCH_RUN);
    i_dcs_far_model.set_ref(16'h7A7A, 16'h2D2D);
    w(3);
    chk("freq", fref, 16'h2D2D);
    ctl(SRC_TERMINAL, MAC_LATCH_RUN);
    chk("freq", fref, 16'h7A7A);
    i_dcs_far_model.set_ref(16'h1111, 16'h2222);
    $display("test src done");
  endtask

  task t_latch();
    logic [31:0] q;
    ctl(SRC_TERMINAL, MAC_LATCH_RUN);
    dc(4'h0, 1'h0, 1'hx);
    dc(4'h1, 1'h1, 1'h0);
    dc(4'h0, 1'h0, 1'hx);
    ctl(SRC_TERMINAL, MAC_LATCH_DIR);
    dc(4'h3, 1'h1, 1'h1);
    rd(OFS_STATUS, q);
    chk("status", q, 32'h1111_0303);
    dc(4'h1, 1'h1, 1'h0);
    dc(4'h0, 1'h0, 1'hx);
    ctl(SRC_TERMINAL, MAC_LATCH_FR);
    dc(4'h2, 1'h1, 1'h1);
    dc(4'h0, 1'h0, 1'hx);
    dc(4'h1, 1'h1, 1'h0);
    dc(4'h0, 1'h0, 1'hx);
    $display("test latch done");
  endtask

  task t_mom();
    logic fs;
    ctl(SRC_TERMINAL, MAC_MOM_START);
    dc(4'h2, 1'h0, 1'hx);
    dc(4'h3, 1'h1, 1'hx);
    dc(4'h2, 1'h1, 1'hx);
    dc(4'h0, 1'h0, 1'hx);
    dc(4'h1, 1'h0, 1'hx);
    dc(4'h3, 1'h0, 1'hx);
    dc(4'h2, 1'h0, 1'hx);
    ctl(SRC_TERMINAL, MAC_MOM_DIR);
    dc(4'h6, 1'h1, 1'h1);
    dc(4'h2, 1'h1, 1'h1);
    dc(4'h0, 1'h0, 1'hx);
    dc(4'h2, 1'h0, 1'hx);
    dc(4'h3, 1'h1, 1'h0);
    dc(4'h0, 1'h0, 1'hx);
    ctl(SRC_TERMINAL, MAC_MOM_PAIR);
    dc(4'hA, 1'h0, 1'hx);
    dc(4'hB, 1'h0, 1'hx);
    dc(4'hA, 1'h0, 1'hx);
    dc(4'hF, 1'h1, 1'hx);
    dc(4'hA, 1'h1, 1'hx);
    i_dcs_far_model.set_di(4'h0);
    fs = 1'h0;
    repeat (8)
    begin
      @(posedge clk);
      fs = fs | fst;
    end
    chk("fast_stop", fs, 1'h1);
    chk("run", run, 1'h0);
    $display("test momentary done");
  endtask

  task t_net();
    ctl(SRC_FIELDBUS, MAC_LATCH_RUN);
    rm(6'h02);
    ck(1'h0, 1'hx);
    rm(6'h00);
    dc(4'h1, 1'h0, 1'hx);
    rm(6'h02);
    ck(1'h1, 1'hx);
    rm(6'h06);
    ck(1'h0, 1'hx);
    rm(6'h00);
    rm(6'h0A);
    ck(1'h1, 1'h1);
    dc(4'h0, 1'h0, 1'hx);
    rm(6'h00);
    ctl(SRC_SLAVE, MAC_LATCH_RUN);
    dc(4'h1, 1'h0, 1'hx);
    i_dcs_far_model.set_mst(1'h1, 1'h0);
    ck(1'h1, 1'h0);
    i_dcs_far_model.set_mst(1'h0, 1'h0);
    ck(1'h0, 1'hx);
    i_dcs_far_model.set_mst(1'h1, 1'h1);
    ck(1'h1, 1'h1);
    dc(4'h0, 1'h0, 1'hx);
    i_dcs_far_model.set_mst(1'h0, 1'h0);
    ctl(SRC_BACNET, MAC_LATCH_RUN);
    dc(4'h1, 1'h0, 1'hx);
    i_dcs_far_model.set_bac(3'h1);
    ck(1'h1, 1'h0);
    i_dcs_far_model.set_bac(3'h3);
    ck(1'h0, 1'hx);
    i_dcs_far_model.set_bac(3'h0);
    i_dcs_far_model.set_bac(3'h5);
    ck(1'h1, 1'h1);
    dc(4'h0, 1'h0, 1'hx);
    i_dcs_far_model.set_bac(3'h0);
    $display("test remote done");
  endtask

  task t_kpd();
    wr(OFS_CFG, 32'h0000_0000);
    ctl(SRC_KEYPAD_A, MAC_LATCH_RUN);
    dc(4'h1, 1'h0, 1'hx);
    rm(6'h10);
    ck(1'h1, 1'hx);
    rm(6'h00);
    rm(6'h20);
    ck(1'h0, 1'hx);
    rm(6'h00);
    dc(4'h0, 1'h0, 1'hx);
    wr(OFS_SPEED, 32'h0000_0456);
    wr(OFS_CFG, 32'h0123_0002);
    ctl(SRC_KEYPAD_B, MAC_LATCH_RUN);
    chk("kp_freq", fref, 16'h0123);
    dc(4'h1, 1'h1, 1'hx);
    chk("kp_freq", fref, 16'h0456);
    dc(4'h0, 1'h0, 1'hx);
    wr(OFS_CFG, 32'h0000_0004);
    dc(4'h1, 1'h1, 1'hx);
    dc(4'h0, 1'h0, 1'hx);
    $display("test keypad done");
  endtask

  // Second reset: configuration is lost, autostart must be armed again
  task t_boot();
    i_dcs_far_model.set_di(4'h0);
    rst_n <= 1'h0;
    repeat (3) @(posedge clk);
    rst_n <= 1'h1;
    w(2);
    chk("hready", hready, 1'h1);
    chk("run", run, 1'h0);
    wr(OFS_CFG, 32'h0000_0001);
    ctl(SRC_KEYPAD_A, MAC_LATCH_RUN);
    dc(4'h1, 1'h1, 1'h0);
    dc(4'h0, 1'h0, 1'hx);
    dc(4'h1, 1'h0, 1'hx);
    $display("test boot done");
  endtask

  initial
  begin
    repeat (5) @(posedge clk);
    rst_n <= 1'h1;
    t_regs();
    t_src();
    t_latch();
    t_mom();
    t_net();
    t_kpd();
    t_boot();
    tally_and_finish();
  end
endmodule
